// [src/scs_clock_control.sv]
// system clock source selection, start-up sequencing and domain clock enables
`timescale 1ns/1ps
`default_nettype none
module scs_clock_control #(
	parameter logic [15:0] WDT_LONG_CYCLES = scs_pkg::WDT_LONG_DEFAULT, // long reset time-out
	parameter logic [15:0] WAKE_XTAL_CK = scs_pkg::WAKE_XTAL_DEFAULT // crystal start-up
) (
	input wire logic ref_clk, // 50 MHz system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [3:0] sourceSelectFuses, // non-volatile source code
	input wire logic [1:0] startupTimeFuses, // non-volatile start-up code
	input wire logic divideByEightSetting, // 0 = programmed, divide by 8
	input wire logic resetPinDisableSetting, // 0 = programmed, reset pin disabled
	input wire logic [7:0] factoryTrim, // factory calibration byte
	input wire logic trimWr, // pulse: write oscillator trim register
	input wire logic [7:0] trimWrData, // new trim value
	input wire logic selWr, // pulse: write runtime select register
	input wire logic [3:0] selWrSource, // new source select field
	input wire logic [1:0] selWrStartup, // new start-up time field
	input wire logic sleepReq, // pulse: enter power-down or power-save
	input wire logic wakeEvent, // pulse: wake from sleep
	input wire logic coreHaltReq, // level: gate core and flash clocks
	input wire logic ioHaltReq, // level: gate I/O clock
	input wire logic adcEnable, // level: converter clock wanted
	input wire logic adcNoiseReduce, // level: halt core and I/O during conversion
	input wire logic asyncUseExt, // level: async timer on external clock
	input wire logic clockOutEnable, // level: drive system clock on line five, except with a crystal or low-frequency source
	input wire logic extClockPin, // external clock input on line four
	input wire logic rcOscClk, // internal RC oscillator
	input wire logic wdtOscClk, // watchdog oscillator
	input wire logic lowFreqOscClk, // low-frequency oscillator
	input wire logic xtalOscClk, // crystal amplifier output
	input wire logic extIntPin, // external interrupt pin
	input wire logic asyncIntClr, // pulse: clear async interrupt flag
	output logic [7:0] oscillatorTrim, // oscillator trim register
	output logic [3:0] sourceSelectField, // runtime source select field
	output logic [1:0] startupTimeField, // runtime start-up field
	output scs_pkg::scs_src_t activeSource, // class of source in use
	output logic [1:0] xtalRange, // crystal range of active code
	output logic [1:0] portBLineFourRole, // role of line four
	output logic [1:0] portBLineFiveRole, // role of line five
	output logic cpuRunning, // instruction execution allowed
	output logic coreClkEn, // core clock enable
	output logic flashClkEn, // flash clock enable
	output logic ioClkEn, // I/O clock enable
	output logic adcClkEn, // converter clock enable
	output logic asyncTimerTick, // async timer clock pulse
	output logic wdtTick, // watchdog oscillator pulse for watchdog timer
	output logic sysClkTick, // divided system clock pulse
	output logic clockOutLevel, // level for clock output pin
	output logic asyncIntFlag // sticky async interrupt flag
);
	logic [scs_pkg::OSC_NUM-1:0] oscPins;
	logic [scs_pkg::OSC_NUM-1:0] oscLevel;
	logic [scs_pkg::OSC_NUM-1:0] oscRise;

	scs_pkg::scs_state_t state_q, state_d;
	logic [3:0] sel_q, sel_d;
	logic [1:0] sut_q, sut_d;
	logic [3:0] active_q, active_d;
	logic div8_q, div8_d;
	logic [7:0] trim_q, trim_d;
	logic [2:0] divCnt_q, divCnt_d;
	logic sysTick_q, sysTick_d;
	logic asyTick_q, asyTick_d;
	logic wdtTick_q, wdtTick_d;
	logic clkOut_q, clkOut_d;
	logic asyInt_q, asyInt_d;

	logic wdtStart;
	logic srcStart;
	logic [15:0] wdtTarget;
	logic [15:0] srcTarget;
	logic wdtDone;
	logic srcDone;
	logic srcTick;
	logic running;
	logic [3:0] countedCode;

	// source class of a four-bit code
	function automatic scs_pkg::scs_src_t srcClass(input logic [3:0] code);
		if (code[3]) begin
			srcClass = scs_pkg::SRC_XTAL;
		end else if (code[2]) begin
			srcClass = scs_pkg::SRC_LOWF;
		end else if (code == scs_pkg::CODE_EXT) begin
			srcClass = scs_pkg::SRC_EXT;
		end else if (code == scs_pkg::CODE_RC) begin
			srcClass = scs_pkg::SRC_RC;
		end else if (code == scs_pkg::CODE_WDT) begin
			srcClass = scs_pkg::SRC_WDT;
		end else begin
			srcClass = scs_pkg::SRC_NONE;
		end
	endfunction

	// start-up cycles of a source after wake-up or switch
	function automatic logic [15:0] wakeCount(input logic [3:0] code);
		unique case (srcClass(code))
			scs_pkg::SRC_RC, scs_pkg::SRC_WDT: wakeCount = scs_pkg::WAKE_INTERNAL_CK;
			scs_pkg::SRC_LOWF: wakeCount = scs_pkg::WAKE_LOWF_CK;
			scs_pkg::SRC_XTAL: wakeCount = WAKE_XTAL_CK;
			default: wakeCount = scs_pkg::WAKE_EXT_CK;
		endcase
	endfunction

	// tick of the oscillator that feeds a code
	function automatic logic codeTick(input logic [3:0] code,
			input logic [scs_pkg::OSC_NUM-1:0] rise);
		unique case (srcClass(code))
			scs_pkg::SRC_EXT: codeTick = rise[scs_pkg::OSC_EXT];
			scs_pkg::SRC_RC: codeTick = rise[scs_pkg::OSC_RC];
			scs_pkg::SRC_WDT: codeTick = rise[scs_pkg::OSC_WDT];
			scs_pkg::SRC_LOWF: codeTick = rise[scs_pkg::OSC_LOWF];
			scs_pkg::SRC_XTAL: codeTick = rise[scs_pkg::OSC_XTAL];
			default: codeTick = 1'b0;
		endcase
	endfunction

	assign oscPins = {extIntPin, xtalOscClk, lowFreqOscClk, wdtOscClk, rcOscClk, extClockPin};

	genvar gi;
	generate
		for (gi = 0; gi < scs_pkg::OSC_NUM; gi++) begin : g_sync
			scs_edge_sync u_sync (
				.ref_clk(ref_clk),
				.rst(rst),
				.pinIn(oscPins[gi]),
				.levelOut(oscLevel[gi]),
				.risePulse(oscRise[gi])
			);
		end
	endgenerate

	// watchdog counter always sees its own oscillator, whatever the device clock
	scs_cycle_counter u_wdt_cnt (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(wdtStart),
		.target(wdtTarget),
		.tick(oscRise[scs_pkg::OSC_WDT]),
		.busy(),
		.done(wdtDone)
	);

	scs_cycle_counter u_src_cnt (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(srcStart),
		.target(srcTarget),
		.tick(srcTick),
		.busy(),
		.done(srcDone)
	);

	// during a switch the pending source is counted, otherwise the active one
	assign countedCode = (state_q == scs_pkg::ST_SWITCH) ? sel_q : active_q;
	assign srcTick = codeTick(countedCode, oscRise);

	// reset time-out on the watchdog oscillator by start-up field
	always_comb begin
		unique case (sut_q)
			scs_pkg::STARTUP_NONE: begin
				if (resetPinDisableSetting == scs_pkg::FUSE_PROGRAMMED) begin
					wdtTarget = scs_pkg::WDT_SHORT_CYCLES;
				end else begin
					wdtTarget = 16'h0000;
				end
			end
			scs_pkg::STARTUP_SHORT: wdtTarget = scs_pkg::WDT_SHORT_CYCLES;
			scs_pkg::STARTUP_LONG: wdtTarget = WDT_LONG_CYCLES;
			scs_pkg::STARTUP_RSVD: wdtTarget = WDT_LONG_CYCLES;
		endcase
	end

	// sequencer and runtime select register
	always_comb begin
		state_d = state_q;
		sel_d = sel_q;
		sut_d = sut_q;
		active_d = active_q;
		wdtStart = 1'b0;
		srcStart = 1'b0;
		srcTarget = scs_pkg::RESET_SRC_CK;
		unique case (state_q)
			scs_pkg::ST_LOAD: begin
				wdtStart = 1'b1;
				state_d = scs_pkg::ST_WDT;
			end
			scs_pkg::ST_WDT: begin
				if (wdtDone) begin
					srcStart = 1'b1;
					srcTarget = scs_pkg::RESET_SRC_CK;
					state_d = scs_pkg::ST_SRC;
				end
			end
			scs_pkg::ST_SRC: begin
				if (srcDone) begin
					state_d = scs_pkg::ST_RUN;
				end
			end
			scs_pkg::ST_RUN: begin
				if (sleepReq) begin
					state_d = scs_pkg::ST_SLEEP;
				end else if (selWr) begin
					sel_d = selWrSource;
					sut_d = selWrStartup;
					if (selWrSource != active_q) begin
						srcStart = 1'b1;
						srcTarget = wakeCount(selWrSource);
						state_d = scs_pkg::ST_SWITCH;
					end
				end
			end
			scs_pkg::ST_SLEEP: begin
				if (wakeEvent) begin
					srcStart = 1'b1;
					srcTarget = wakeCount(active_q);
					state_d = scs_pkg::ST_SRC;
				end
			end
			scs_pkg::ST_SWITCH: begin
				if (srcDone) begin
					active_d = sel_q;
					state_d = scs_pkg::ST_RUN;
				end
			end
			default: state_d = scs_pkg::ST_LOAD;
		endcase
	end

	assign running = (state_q == scs_pkg::ST_RUN);

	// trim, divider, ticks and async interrupt flag
	always_comb begin
		trim_d = trim_q;
		if (trimWr) begin
			trim_d = trimWrData;
		end
		divCnt_d = divCnt_q;
		sysTick_d = 1'b0;
		if (running && codeTick(active_q, oscRise)) begin
			divCnt_d = divCnt_q + 3'h1;
			if (div8_q == scs_pkg::FUSE_PROGRAMMED) begin
				sysTick_d = (divCnt_q == scs_pkg::DIV8_LAST);
			end else begin
				sysTick_d = 1'b1;
			end
		end
		clkOut_d = clkOut_q;
		if (sysTick_q) begin
			clkOut_d = ~clkOut_q;
		end
		if (asyncUseExt) begin
			asyTick_d = oscRise[scs_pkg::OSC_EXT];
		end else begin
			asyTick_d = oscRise[scs_pkg::OSC_LOWF];
		end
		wdtTick_d = oscRise[scs_pkg::OSC_WDT];
		// edge caught regardless of the I/O clock enable; a new edge beats the clear
		asyInt_d = asyInt_q;
		if (asyncIntClr) begin
			asyInt_d = 1'b0;
		end
		if (oscRise[scs_pkg::OSC_EXTINT]) begin
			asyInt_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= scs_pkg::ST_LOAD;
			sel_q <= sourceSelectFuses;
			sut_q <= startupTimeFuses;
			active_q <= sourceSelectFuses;
			div8_q <= divideByEightSetting;
			trim_q <= factoryTrim;
			divCnt_q <= 3'h0;
			sysTick_q <= 1'b0;
			asyTick_q <= 1'b0;
			wdtTick_q <= 1'b0;
			clkOut_q <= 1'b0;
			asyInt_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sel_q <= sel_d;
			sut_q <= sut_d;
			active_q <= active_d;
			div8_q <= div8_d;
			trim_q <= trim_d;
			divCnt_q <= divCnt_d;
			sysTick_q <= sysTick_d;
			asyTick_q <= asyTick_d;
			wdtTick_q <= wdtTick_d;
			clkOut_q <= clkOut_d;
			asyInt_q <= asyInt_d;
		end
	end

	assign div8_d = div8_q;

	// pin roles follow the code in use
	always_comb begin
		unique case (srcClass(active_q))
			scs_pkg::SRC_EXT: portBLineFourRole = scs_pkg::ROLE_CLKIN;
			scs_pkg::SRC_LOWF, scs_pkg::SRC_XTAL: portBLineFourRole = scs_pkg::ROLE_OSC;
			default: portBLineFourRole = scs_pkg::ROLE_IO;
		endcase
		if ((srcClass(active_q) == scs_pkg::SRC_LOWF) || (srcClass(active_q) == scs_pkg::SRC_XTAL)) begin
			portBLineFiveRole = scs_pkg::ROLE_OSC;
		end else if (clockOutEnable) begin
			portBLineFiveRole = scs_pkg::ROLE_CLKOUT;
		end else begin
			portBLineFiveRole = scs_pkg::ROLE_IO;
		end
	end

	assign oscillatorTrim = trim_q;
	assign sourceSelectField = sel_q;
	assign startupTimeField = sut_q;
	assign activeSource = srcClass(active_q);
	assign xtalRange = active_q[3] ? active_q[2:1] : 2'h0;
	assign cpuRunning = running;
	assign coreClkEn = running && !coreHaltReq && !adcNoiseReduce;
	assign flashClkEn = coreClkEn;
	assign ioClkEn = running && !ioHaltReq && !adcNoiseReduce;
	assign adcClkEn = adcEnable && (running || adcNoiseReduce);
	assign asyncTimerTick = asyTick_q;
	assign wdtTick = wdtTick_q;
	assign sysClkTick = sysTick_q;
	assign clockOutLevel = clkOut_q && (portBLineFiveRole == scs_pkg::ROLE_CLKOUT);
	assign asyncIntFlag = asyInt_q;
endmodule
`default_nettype wire

// [src/scs_pkg.sv]
// constants, codes and timing counts for the system clock source select block
package scs_pkg;
	localparam logic [3:0] CODE_EXT = 4'h0;
	localparam logic [3:0] CODE_RC = 4'h2;
	localparam logic [3:0] CODE_WDT = 4'h3;
	localparam logic [1:0] STARTUP_NONE = 2'h0;
	localparam logic [1:0] STARTUP_SHORT = 2'h1;
	localparam logic [1:0] STARTUP_LONG = 2'h2;
	localparam logic [1:0] STARTUP_RSVD = 2'h3;
	localparam logic FUSE_PROGRAMMED = 1'h0;
	localparam logic FUSE_UNPROGRAMMED = 1'h1;
	// factory defaults
	localparam logic [3:0] DEFAULT_CODE = 4'h2;
	localparam logic [1:0] DEFAULT_STARTUP = 2'h2;
	localparam logic DEFAULT_DIV8 = 1'h0;
	// source classes
	typedef enum logic [2:0] {
		SRC_EXT = 3'h0,
		SRC_RC = 3'h1,
		SRC_WDT = 3'h2,
		SRC_LOWF = 3'h3,
		SRC_XTAL = 3'h4,
		SRC_NONE = 3'h5
	} scs_src_t;
	// pin roles
	localparam logic [1:0] ROLE_IO = 2'h0;
	localparam logic [1:0] ROLE_CLKIN = 2'h1;
	localparam logic [1:0] ROLE_OSC = 2'h2;
	localparam logic [1:0] ROLE_CLKOUT = 2'h3;
	// oscillator pin indices in the sampled vector
	localparam int OSC_NUM = 6;
	localparam int OSC_EXT = 0;
	localparam int OSC_RC = 1;
	localparam int OSC_WDT = 2;
	localparam int OSC_LOWF = 3;
	localparam int OSC_XTAL = 4;
	localparam int OSC_EXTINT = 5;
	// counts in cycles of the counted oscillator
	localparam int CNT_W = 16;
	localparam logic [15:0] WAKE_INTERNAL_CK = 16'h0006;
	localparam logic [15:0] WAKE_EXT_CK = 16'h0006;
	localparam logic [15:0] WAKE_LOWF_CK = 16'h0400;
	localparam logic [15:0] RESET_SRC_CK = 16'h000E;
	localparam logic [15:0] WDT_SHORT_CYCLES = 16'h0200;
	localparam logic [15:0] WDT_LONG_DEFAULT = 16'h2000;
	localparam logic [15:0] WAKE_XTAL_DEFAULT = 16'h4000;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	// sequencer states, gray along load, watchdog wait, source wait, run
	typedef enum logic [2:0] {
		ST_LOAD = 3'h0,
		ST_WDT = 3'h1,
		ST_SRC = 3'h3,
		ST_RUN = 3'h2,
		ST_SLEEP = 3'h6,
		ST_SWITCH = 3'h7
	} scs_state_t;
endpackage

// [src/scs_edge_sync.sv]
// two-flop synchroniser with rising-edge pulse for one oscillator or pin
`timescale 1ns/1ps
`default_nettype none
module scs_edge_sync (
	input wire logic ref_clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic pinIn, // asynchronous level
	output logic levelOut, // synchronised level
	output logic risePulse // one-cycle pulse on rising edge
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	logic meta_d;
	logic sync_d;
	logic last_d;

	always_comb begin
		meta_d = pinIn;
		sync_d = meta_q;
		last_d = sync_q;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	assign levelOut = sync_q;
	assign risePulse = sync_q & ~last_q;
endmodule
`default_nettype wire

// [src/scs_cycle_counter.sv]
// counts oscillator ticks down from a loaded target and pulses when finished
`timescale 1ns/1ps
`default_nettype none
module scs_cycle_counter (
	input wire logic ref_clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic start, // pulse: load target and begin
	input wire logic [15:0] target, // ticks to wait
	input wire logic tick, // one pulse per counted oscillator cycle
	output logic busy, // counting
	output logic done // one-cycle pulse at end
);
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic done_d;

	always_comb begin
		count_d = count_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (start) begin
			count_d = target;
			busy_d = 1'b1;
		end else if (busy_q && (count_q == 16'h0000)) begin
			busy_d = 1'b0;
			done_d = 1'b1;
		end else if (busy_q && tick) begin
			count_d = count_q - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_q <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			count_q <= count_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
endmodule
`default_nettype wire

// [tb/scs_clock_control_chk.sv]
// concurrent checks on the clock control ports
`timescale 1ns/1ps
`default_nettype none
module scs_clock_control_chk #(
	parameter logic [15:0] WDT_LONG_CYCLES = 16'h2000, // long reset time-out
	parameter logic [15:0] WAKE_XTAL_CK = 16'h4000 // crystal start-up
) (
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic [3:0] sourceSelectFuses, // code setting
	input wire logic [1:0] startupTimeFuses, // start-up setting
	input wire logic [7:0] factoryTrim, // calibration byte
	input wire logic selWr, // select write
	input wire logic [3:0] selWrSource, // new code
	input wire logic sleepReq, // sleep
	input wire logic coreHaltReq, // core halt
	input wire logic adcEnable, // converter wanted
	input wire logic adcNoiseReduce, // noise reduction
	input wire logic clockOutEnable, // clock out wanted
	input wire logic [7:0] oscillatorTrim, // trim
	input wire logic [3:0] sourceSelectField, // code field
	input wire logic [1:0] startupTimeField, // start-up field
	input wire scs_pkg::scs_src_t activeSource, // source class
	input wire logic [1:0] xtalRange, // crystal range
	input wire logic [1:0] portBLineFourRole, // line four
	input wire logic [1:0] portBLineFiveRole, // line five
	input wire logic cpuRunning, // running
	input wire logic coreClkEn, // core enable
	input wire logic flashClkEn, // flash enable
	input wire logic ioClkEn, // I/O enable
	input wire logic adcClkEn, // converter enable
	input wire logic wdtTick, // watchdog tick
	input wire logic asyncIntFlag // async flag
);
	// bench watchdog oscillator period is 15 cycles
	localparam logic [4:0] WDT_GAP_MAX = 5'h18;
	scs_pkg::scs_src_t expSrc;
	logic [1:0] expFour, expFive;
	logic [4:0] wdtGap_q, wdtGap_d;
	logic osc;
	always_comb begin
		osc = sourceSelectField[3] | sourceSelectField[2];
		if (sourceSelectField[3]) expSrc = scs_pkg::SRC_XTAL;
		else if (sourceSelectField[2]) expSrc = scs_pkg::SRC_LOWF;
		else if (sourceSelectField == scs_pkg::CODE_EXT) expSrc = scs_pkg::SRC_EXT;
		else if (sourceSelectField == scs_pkg::CODE_RC) expSrc = scs_pkg::SRC_RC;
		else if (sourceSelectField == scs_pkg::CODE_WDT) expSrc = scs_pkg::SRC_WDT;
		else expSrc = scs_pkg::SRC_NONE;
		expFour = osc ? scs_pkg::ROLE_OSC : (expSrc == scs_pkg::SRC_EXT) ? scs_pkg::ROLE_CLKIN :
			scs_pkg::ROLE_IO;
		expFive = osc ? scs_pkg::ROLE_OSC : clockOutEnable ? scs_pkg::ROLE_CLKOUT : scs_pkg::ROLE_IO;
		wdtGap_d = wdtTick ? 5'h00 : (wdtGap_q == 5'h1F) ? wdtGap_q : wdtGap_q + 5'h01;
	end
	always_ff @(posedge ref_clk) begin
		wdtGap_q <= rst ? 5'h00 : wdtGap_d;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_FLASH_WITH_CORE:
		assert property (flashClkEn == coreClkEn) else $error("flash enable differs from core");
	AST_CORE_GATE:
		assert property (coreClkEn |-> cpuRunning && !coreHaltReq && !adcNoiseReduce)
		else $error("core clock on while halted");
	AST_ADC_SEPARATE:
		assert property (adcEnable && adcNoiseReduce |-> adcClkEn && !coreClkEn && !ioClkEn)
		else $error("converter domain not separate");
	AST_TRIM_RESET:
		assert property ($fell(rst) |-> oscillatorTrim == $past(factoryTrim))
		else $error("trim not loaded at reset");
	AST_FIELDS_RESET:
		assert property ($fell(rst) |-> {sourceSelectField, startupTimeField} ==
			{$past(sourceSelectFuses), $past(startupTimeFuses)}) else $error("fields not copied");
	AST_DECODE:
		assert property (cpuRunning |-> activeSource == expSrc) else $error("source decode wrong");
	AST_XTAL_RANGE:
		assert property (cpuRunning && sourceSelectField[3] |-> xtalRange == sourceSelectField[2:1])
		else $error("crystal range wrong");
	AST_PIN_ROLE:
		assert property (cpuRunning |-> portBLineFourRole == expFour && portBLineFiveRole == expFive)
		else $error("pin role wrong");
	AST_SWITCH_HOLD:
		assert property (cpuRunning && selWr && !sleepReq && selWrSource != sourceSelectField |=>
			!cpuRunning && !coreClkEn && sourceSelectField == $past(selWrSource))
		else $error("switch did not hold clock");
	AST_SLEEP_STOP:
		assert property (cpuRunning && sleepReq |=> !cpuRunning ##1 !cpuRunning)
		else $error("still running after sleep");
	AST_WDT_RUNS:
		assert property (wdtGap_q < WDT_GAP_MAX) else $error("watchdog ticks stopped");
	cover property (cpuRunning && selWr);
	cover property ($rose(cpuRunning));
	cover property ($rose(asyncIntFlag));
endmodule
bind scs_clock_control scs_clock_control_chk #(.WDT_LONG_CYCLES(WDT_LONG_CYCLES),
	.WAKE_XTAL_CK(WAKE_XTAL_CK)) chk_u (.ref_clk, .rst, .sourceSelectFuses, .startupTimeFuses,
	.factoryTrim, .selWr, .selWrSource, .sleepReq, .coreHaltReq, .adcEnable, .adcNoiseReduce,
	.clockOutEnable, .oscillatorTrim, .sourceSelectField, .startupTimeField, .activeSource,
	.xtalRange, .portBLineFourRole, .portBLineFiveRole, .cpuRunning, .coreClkEn, .flashClkEn,
	.ioClkEn, .adcClkEn, .wdtTick, .asyncIntFlag);
`default_nettype wire

// [tb/scs_osc_model.sv]
// oscillator and external clock sources facing the clock control block
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
	parameter int EXT_HALF = 50, // ns
	parameter int RC_HALF = 60, // ns
	parameter int WDT_HALF = 150, // ns
	parameter int LOWF_HALF = 40, // ns
	parameter int XTAL_HALF = 30 // ns
) (
	output logic extClockPin, // external clock
	output logic rcOscClk, // RC oscillator
	output logic wdtOscClk, // watchdog oscillator
	output logic lowFreqOscClk, // low-frequency oscillator
	output logic xtalOscClk // crystal amplifier
);
	initial begin
		extClockPin = 1'b0;
		rcOscClk = 1'b0;
		wdtOscClk = 1'b0;
		lowFreqOscClk = 1'b0;
		xtalOscClk = 1'b0;
	end
	always #(EXT_HALF) extClockPin = ~extClockPin;
	always #(RC_HALF) rcOscClk = ~rcOscClk;
	// runs in every state, sleep included
	always #(WDT_HALF) wdtOscClk = ~wdtOscClk;
	always #(LOWF_HALF) lowFreqOscClk = ~lowFreqOscClk;
	always #(XTAL_HALF) xtalOscClk = ~xtalOscClk;
endmodule
`default_nettype wire

// [tb/system_clock_source_select_startup_test.sv]
// self-checking testbench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_startup_test;
	logic ref_clk = 1'b0, rst = 1'b1;
	logic [3:0] sourceSelectFuses = 4'h2, selWrSource = 4'h0;
	logic [1:0] startupTimeFuses = 2'h2, selWrStartup = 2'h0;
	logic divideByEightSetting = 1'b0, resetPinDisableSetting = 1'b1, trimWr = 1'b0, selWr = 1'b0;
	logic [7:0] factoryTrim = 8'h00, trimWrData = 8'h00;
	logic sleepReq = 1'b0, wakeEvent = 1'b0, coreHaltReq = 1'b0, ioHaltReq = 1'b0;
	logic adcEnable = 1'b0, adcNoiseReduce = 1'b0, asyncUseExt = 1'b0, clockOutEnable = 1'b0;
	logic extIntPin = 1'b0, asyncIntClr = 1'b0;
	wire extClockPin, rcOscClk, wdtOscClk, lowFreqOscClk, xtalOscClk;
	logic [7:0] oscillatorTrim;
	logic [3:0] sourceSelectField;
	logic [1:0] startupTimeField, xtalRange, portBLineFourRole, portBLineFiveRole;
	scs_pkg::scs_src_t activeSource;
	logic cpuRunning, coreClkEn, flashClkEn, ioClkEn, adcClkEn, asyncTimerTick, wdtTick;
	logic sysClkTick, clockOutLevel, asyncIntFlag;
	int miscompares = 0, samplesChecked = 0, n, cyc, k;
	logic [1:0] suTab [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
	logic [14:0] v;
	localparam logic [15:0] LONG_CYC = 16'h0010;
	scs_clock_control #(.WDT_LONG_CYCLES(LONG_CYC), .WAKE_XTAL_CK(16'h0008)) dut_u (.ref_clk, .rst,
		.sourceSelectFuses, .startupTimeFuses, .divideByEightSetting, .resetPinDisableSetting,
		.factoryTrim, .trimWr, .trimWrData, .selWr, .selWrSource, .selWrStartup, .sleepReq,
		.wakeEvent, .coreHaltReq, .ioHaltReq, .adcEnable, .adcNoiseReduce, .asyncUseExt,
		.clockOutEnable, .extClockPin, .rcOscClk, .wdtOscClk, .lowFreqOscClk, .xtalOscClk,
		.extIntPin, .asyncIntClr, .oscillatorTrim, .sourceSelectField, .startupTimeField,
		.activeSource, .xtalRange, .portBLineFourRole, .portBLineFiveRole, .cpuRunning, .coreClkEn,
		.flashClkEn, .ioClkEn, .adcClkEn, .asyncTimerTick, .wdtTick, .sysClkTick, .clockOutLevel,
		.asyncIntFlag);
	scs_osc_model osc_u (.extClockPin, .rcOscClk, .wdtOscClk, .lowFreqOscClk, .xtalOscClk);
	always #10 ref_clk = ~ref_clk;
	task automatic summarize;
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		samplesChecked++;
		if ($isunknown(got) || got < lo || got > hi) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, lo);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge ref_clk);
	endtask
	// waits for execution to start, counting cycles and watchdog ticks
	task automatic waitRun;
		n = 0;
		cyc = 0;
		while (cpuRunning !== 1'b1 && cyc < 20000) begin
			@(negedge ref_clk);
			cyc++;
			if (wdtTick === 1'b1) n++;
		end
		cmp(cyc, 0, 19999);
	endtask
	task automatic count(input logic useAsync);
		k = 0;
		repeat (600) begin
			@(negedge ref_clk);
			if ((useAsync ? asyncTimerTick : sysClkTick) === 1'b1) k++;
		end
	endtask
	task automatic doReset(input logic [3:0] c, input logic [1:0] s, input logic d8, input logic rp);
		sourceSelectFuses = c;
		startupTimeFuses = s;
		divideByEightSetting = d8;
		resetPinDisableSetting = rp;
		factoryTrim = 8'($urandom);
		rst = 1'b1;
		tick(20);
		cmp(oscillatorTrim, factoryTrim, factoryTrim);
		cmp({sourceSelectField, startupTimeField, cpuRunning}, {c, s, 1'b0}, {c, s, 1'b0});
		rst = 1'b0;
		waitRun;
	endtask
	task automatic setSel(input logic [3:0] c, input logic [1:0] s);
		selWrSource = c;
		selWrStartup = s;
		selWr = 1'b1;
		tick(1);
		selWr = 1'b0;
	endtask
	function automatic logic [31:0] expWdt(input logic [1:0] s, input logic rp);
		return (s == 2'h0) ? (rp ? 0 : 512) : (s == 2'h1) ? 512 : LONG_CYC;
	endfunction
	function automatic logic [14:0] expView(input logic [3:0] c, input logic [1:0] s, input logic ce);
		logic osc;
		logic [2:0] src;
		logic [1:0] four;
		osc = c[3] | c[2];
		src = c[3] ? scs_pkg::SRC_XTAL : c[2] ? scs_pkg::SRC_LOWF : (c == scs_pkg::CODE_EXT) ?
			scs_pkg::SRC_EXT : (c == scs_pkg::CODE_RC) ? scs_pkg::SRC_RC : scs_pkg::SRC_WDT;
		four = osc ? scs_pkg::ROLE_OSC : (c == 4'h0) ? scs_pkg::ROLE_CLKIN : scs_pkg::ROLE_IO;
		return {c, s, src, four, osc ? scs_pkg::ROLE_OSC : ce ? scs_pkg::ROLE_CLKOUT :
			scs_pkg::ROLE_IO, c[3] ? c[2:1] : 2'h0};
	endfunction
	initial begin
		#1500us;
		miscompares++;
		summarize();
	end
	initial begin
		void'($urandom(65));
		doReset(scs_pkg::DEFAULT_CODE, scs_pkg::DEFAULT_STARTUP, scs_pkg::DEFAULT_DIV8, 1'b1);
		cmp(n, LONG_CYC, LONG_CYC + 8);
		count(1'b0);
		cmp(k, 11, 14);
		for (int i = 0; i < 5; i++) begin
			doReset(scs_pkg::CODE_RC, suTab[i], i == 4, i != 1);
			cmp(n, expWdt(suTab[i], i != 1), expWdt(suTab[i], i != 1) + 8);
		end
		count(1'b0);
		cmp(k, 97, 103);
		for (int i = 0; i < 16; i++) begin
			if (i == 1) continue;
			clockOutEnable = 1'($urandom);
			v = expView(i[3:0], 2'($urandom), clockOutEnable);
			setSel(v[14:11], v[10:9]);
			cmp(cpuRunning, 0, 0);
			waitRun;
			cmp({sourceSelectField, startupTimeField, activeSource, portBLineFourRole,
				portBLineFiveRole, xtalRange}, v, v);
		end
		setSel(4'hF, 2'h1);
		cmp({cpuRunning, startupTimeField}, 3'h5, 3'h5);
		tick(1);
		setSel(scs_pkg::CODE_RC, 2'h2);
		waitRun;
		ioHaltReq = 1'b1;
		sleepReq = 1'b1;
		tick(1);
		sleepReq = 1'b0;
		cmp(cpuRunning, 0, 0);
		extIntPin = 1'b1;
		count(1'b1);
		cmp(k, 140, 160);
		cmp(asyncIntFlag, 1, 1);
		wakeEvent = 1'b1;
		tick(1);
		wakeEvent = 0;
		waitRun;
		cmp(cyc, 30, 60);
		asyncIntClr = 1'b1;
		tick(1);
		asyncIntClr = 1'b0;
		extIntPin = 1'b0;
		tick(1);
		cmp(asyncIntFlag, 0, 0);
		trimWrData = 8'($urandom);
		trimWr = 1'b1;
		tick(1);
		trimWr = 1'b0;
		cmp(oscillatorTrim, trimWrData, trimWrData);
		ioHaltReq = 1'b0;
		adcEnable = 1'b1;
		adcNoiseReduce = 1'b1;
		tick(1);
		cmp({adcClkEn, coreClkEn, ioClkEn, flashClkEn}, 4'h8, 4'h8);
		adcNoiseReduce = 1'b0;
		coreHaltReq = 1'b1;
		tick(1);
		cmp({adcClkEn, coreClkEn, ioClkEn, flashClkEn}, 4'hA, 4'hA);
		coreHaltReq = 1'b0;
		tick(1);
		cmp({adcClkEn, coreClkEn, ioClkEn, flashClkEn}, 4'hF, 4'hF);
		asyncUseExt = 1'b1;
		count(1'b1);
		cmp(k, 118, 122);
		clockOutEnable = 1'b0;
		tick(1);
		cmp({clockOutLevel, portBLineFiveRole}, 3'h0, 3'h0);
		clockOutEnable = 1'b1;
		k = 0;
		repeat (12) begin
			@(negedge ref_clk);
			if (clockOutLevel === 1'b1) k++;
		end
		cmp(k, 5, 7);
		summarize();
	end
endmodule
`default_nettype wire
